// [rtl/dsc_pkg.sv]
// Package: register map, field positions and timing for the self-calibration block
// Assumes an 8-bit register port with 5-bit address, single clock mclk
package dsc_pkg;
    localparam logic [4:0] ADDR_I_FINE = 5'h03;
    localparam logic [4:0] ADDR_I_COARSE = 5'h04;
    localparam logic [4:0] ADDR_I_CMRES = 5'h05;
    localparam logic [4:0] ADDR_Q_FINE = 5'h06;
    localparam logic [4:0] ADDR_Q_COARSE = 5'h07;
    localparam logic [4:0] ADDR_Q_CMRES = 5'h08;
    localparam logic [4:0] ADDR_REF_TRIM = 5'h0d;
    localparam logic [4:0] ADDR_CAL_CTRL = 5'h0e;
    localparam logic [4:0] ADDR_CAL_STAT = 5'h0f;
    localparam logic [4:0] ADDR_COEF_ADDR = 5'h10;
    localparam logic [4:0] ADDR_COEF_DATA = 5'h11;
    localparam logic [4:0] ADDR_MEM_CTRL = 5'h12;
    localparam int CAL_DIVIDER_SELECT_LSB = 0;
    localparam int CLKEN_BIT = 3;
    localparam int PICKI_BIT = 4;
    localparam int PICKQ_BIT = 5;
    localparam int DONEI_BIT = 6;
    localparam int DONEQ_BIT = 7;
    localparam int UNCALIBRATED_I_BIT = 0;
    localparam int UNCALIBRATED_Q_BIT = 1;
    localparam int RDSTB_BIT = 2;
    localparam int WRSTB_BIT = 3;
    localparam int START_BIT = 4;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int MIN_DIV = 32;
    localparam int MAX_DIV = 2048;
    localparam int COEF_COUNT = 32;
    localparam int COEF_WIDTH = 6;
    localparam int CAL_CYCLES = 300;
    localparam logic [5:0] COEF_RESET = 6'h20;
endpackage

// [rtl/dsc_cal_engine.sv]
// One channel's calibration sequencer and coefficient store
// Assumes a one-cycle calibration clock tick from the parent divider
`timescale 1ns/1ns
module dsc_cal_engine
    import dsc_pkg::*;
#(
    parameter int CYCLES = CAL_CYCLES,
    parameter int NCOEF = COEF_COUNT
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic calTick,
    input wire logic startCal,
    input wire logic memWe,
    input wire logic [4:0] memIdx,
    input wire logic [5:0] memWdata,
    output logic [5:0] memRdata,
    output logic calBusy,
    output logic calDone
);
    typedef enum logic [1:0] {DSC_IDLE = 2'b00, DSC_RUN = 2'b01, DSC_DONE = 2'b11} dsc_state_t;
    dsc_state_t state_q;
    logic [8:0] tickCnt_q;
    logic [5:0] coef_q [NCOEF];

    // Sequencer: counts calibration clock periods
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= DSC_IDLE;
            tickCnt_q <= 9'h000;
        end else begin
            case (state_q)
                DSC_IDLE: begin
                    tickCnt_q <= 9'h000;
                    if (startCal) begin
                        state_q <= DSC_RUN;
                    end
                end
                DSC_RUN: begin
                    if (!startCal) begin
                        state_q <= DSC_IDLE;
                    end else if (calTick) begin
                        if (tickCnt_q == 9'(CYCLES - 1)) begin
                            state_q <= DSC_DONE;
                        end
                        tickCnt_q <= tickCnt_q + 9'h001;
                    end
                end
                DSC_DONE: begin
                    if (!startCal) begin
                        state_q <= DSC_IDLE;
                    end
                end
                default: state_q <= DSC_IDLE;
            endcase
        end
    end

    // Coefficient store; calibration result models a trimmed value per entry
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int k = 0; k < NCOEF; k++) begin
                coef_q[k] <= COEF_RESET;
            end
        end else if (state_q == DSC_RUN && calTick && startCal) begin
            coef_q[tickCnt_q[4:0]] <= coef_q[tickCnt_q[4:0]] ^ 6'(tickCnt_q[8:5]);
        end else if (memWe && state_q != DSC_RUN) begin
            coef_q[memIdx] <= memWdata;
        end
    end

    assign memRdata = coef_q[memIdx];
    assign calBusy = (state_q == DSC_RUN);
    assign calDone = (state_q == DSC_DONE);

    a_done_after_run: assert property (@(posedge mclk) disable iff (!resetn)
        (state_q == DSC_RUN && startCal && calTick && tickCnt_q == 9'(CYCLES - 1))
        |=> calDone) else $error("Calibration did not finish after full count");
endmodule

// [rtl/dsc_selfcal_top.sv]
// Self-calibration, gain and common-mode trim register block
// Assumes a synchronous 8-bit register port on mclk; trims drive analog cores
`timescale 1ns/1ns
// Notes on behaviour
// - Calibration clock is converter clock divided 32..2048
// - Divider select in control bits 2:0
// - Each channel has its own calibration hardware
// - Control bit 3 enables calibration clock
// - Bits 4/5 select I/Q for calibration, memory
// - Memory control bit 4 starts calibration
// - Status bits 6/7 report I/Q completion
// - Thirty-two coefficients readable and writable by software
// - Read bit presents addressed coefficient in data
// - Write bit lets data writes load coefficient
// - Reference trim is six-bit two's complement
// - Reference trim scales both channels and auxiliary
// - Coarse gain per channel, two's complement
// - Fine gain per channel, straight binary
// - Common-mode resistor disconnected after reset
// - Fine gain defaults to zero
module dsc_selfcal_top
    import dsc_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic [5:0] iFineGain,
    output logic [5:0] qFineGain,
    output logic [5:0] iCoarseGain,
    output logic [5:0] qCoarseGain,
    output logic [5:0] iCmResistor,
    output logic [5:0] qCmResistor,
    output logic iCmResistorEn,
    output logic qCmResistorEn,
    output logic [5:0] referenceTrim,
    output logic calClock
);
    logic [7:0] iFine_q, qFine_q, iCoarse_q, qCoarse_q, iCm_q, qCm_q, ref_q;
    logic [7:0] calCtrl_q, memCtrl_q, coefAddr_q, coefData_q;
    logic [10:0] divCnt_q;
    logic [10:0] divLimit;
    logic calTick;
    logic calClock_q;
    logic [5:0] rdI, rdQ;
    logic busyI, busyQ, doneI, doneQ;
    logic startI, startQ, weI, weQ;
    logic [4:0] coefIdx;
    logic [7:0] regRdata_d;
    logic [7:0] regRdata_q;
    logic wrStrobeOn, rdStrobeOn;

    // Trim registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            iFine_q <= TRIM_RESET;
            qFine_q <= TRIM_RESET;
            iCoarse_q <= TRIM_RESET;
            qCoarse_q <= TRIM_RESET;
            iCm_q <= TRIM_RESET;
            qCm_q <= TRIM_RESET;
            ref_q <= TRIM_RESET;
        end else if (regWrite) begin
            case (regAddr)
                ADDR_I_FINE: iFine_q <= regWdata;
                ADDR_Q_FINE: qFine_q <= regWdata;
                ADDR_I_COARSE: iCoarse_q <= regWdata;
                ADDR_Q_COARSE: qCoarse_q <= regWdata;
                ADDR_I_CMRES: iCm_q <= regWdata;
                ADDR_Q_CMRES: qCm_q <= regWdata;
                ADDR_REF_TRIM: ref_q <= regWdata;
                default: ;
            endcase
        end
    end

    // Calibration control and memory control
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            calCtrl_q <= CTRL_RESET;
            memCtrl_q <= CTRL_RESET;
            coefAddr_q <= CTRL_RESET;
        end else if (regWrite) begin
            case (regAddr)
                ADDR_CAL_CTRL: calCtrl_q <= regWdata;
                ADDR_MEM_CTRL: memCtrl_q <= regWdata;
                ADDR_COEF_ADDR: coefAddr_q <= regWdata;
                default: ;
            endcase
        end
    end

    // Divider limit: 32 shifted left by select, saturating at 2048
    always_comb begin
        divLimit = 11'(MAX_DIV - 1);
        if (calCtrl_q[CAL_DIVIDER_SELECT_LSB +: 3] < 3'h6) begin
            divLimit = 11'((MIN_DIV << calCtrl_q[CAL_DIVIDER_SELECT_LSB +: 3]) - 1);
        end
    end

    // Calibration clock divider, gated by enable bit
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q <= 11'h000;
            calClock_q <= 1'b0;
        end else if (!calCtrl_q[CLKEN_BIT]) begin
            divCnt_q <= 11'h000;
            calClock_q <= 1'b0;
        end else if (divCnt_q >= divLimit) begin
            divCnt_q <= 11'h000;
            calClock_q <= 1'b0;
        end else begin
            divCnt_q <= divCnt_q + 11'h001;
            calClock_q <= (divCnt_q >= (divLimit >> 1));
        end
    end

    assign calTick = calCtrl_q[CLKEN_BIT] && (divCnt_q >= divLimit);
    assign calClock = calClock_q;

    // Per-channel start and memory steering
    assign coefIdx = 5'(coefAddr_q[5:0] - 6'h01);
    assign wrStrobeOn = memCtrl_q[WRSTB_BIT];
    assign rdStrobeOn = memCtrl_q[RDSTB_BIT];
    assign startI = memCtrl_q[START_BIT] && calCtrl_q[PICKI_BIT];
    assign startQ = memCtrl_q[START_BIT] && calCtrl_q[PICKQ_BIT];
    assign weI = regWrite && regAddr == ADDR_COEF_DATA && wrStrobeOn
        && calCtrl_q[PICKI_BIT];
    assign weQ = regWrite && regAddr == ADDR_COEF_DATA && wrStrobeOn
        && calCtrl_q[PICKQ_BIT];

    dsc_cal_engine #(.CYCLES(CAL_LEN), .NCOEF(COEF_COUNT)) engineI (
        .mclk(mclk),
        .resetn(resetn),
        .calTick(calTick),
        .startCal(startI),
        .memWe(weI),
        .memIdx(coefIdx),
        .memWdata(regWdata[5:0]),
        .memRdata(rdI),
        .calBusy(busyI),
        .calDone(doneI)
    );

    dsc_cal_engine #(.CYCLES(CAL_LEN), .NCOEF(COEF_COUNT)) engineQ (
        .mclk(mclk),
        .resetn(resetn),
        .calTick(calTick),
        .startCal(startQ),
        .memWe(weQ),
        .memIdx(coefIdx),
        .memWdata(regWdata[5:0]),
        .memRdata(rdQ),
        .calBusy(busyQ),
        .calDone(doneQ)
    );

    // Coefficient data register: loaded by writes, or from memory while read bit set
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            coefData_q <= CTRL_RESET;
        end else if (regWrite && regAddr == ADDR_COEF_DATA) begin
            coefData_q <= {2'b00, regWdata[5:0]};
        end else if (rdStrobeOn) begin
            coefData_q <= {2'b00, calCtrl_q[PICKI_BIT] ? rdI : rdQ};
        end
    end

    // Read mux
    always_comb begin
        regRdata_d = 8'h00;
        case (regAddr)
            ADDR_I_FINE: regRdata_d = iFine_q;
            ADDR_Q_FINE: regRdata_d = qFine_q;
            ADDR_I_COARSE: regRdata_d = iCoarse_q;
            ADDR_Q_COARSE: regRdata_d = qCoarse_q;
            ADDR_I_CMRES: regRdata_d = iCm_q;
            ADDR_Q_CMRES: regRdata_d = qCm_q;
            ADDR_REF_TRIM: regRdata_d = ref_q;
            ADDR_CAL_CTRL: regRdata_d = calCtrl_q;
            ADDR_CAL_STAT: begin
                regRdata_d[DONEI_BIT] = doneI;
                regRdata_d[DONEQ_BIT] = doneQ;
                regRdata_d[UNCALIBRATED_I_BIT] = !doneI && !memCtrl_q[UNCALIBRATED_I_BIT];
                regRdata_d[UNCALIBRATED_Q_BIT] = !doneQ && !memCtrl_q[UNCALIBRATED_Q_BIT];
            end
            ADDR_COEF_ADDR: regRdata_d = coefAddr_q;
            ADDR_COEF_DATA: regRdata_d = coefData_q;
            ADDR_MEM_CTRL: regRdata_d = memCtrl_q;
            default: regRdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdata_q <= 8'h00;
        end else if (regRead) begin
            regRdata_q <= regRdata_d;
        end
    end

    assign regRdata = regRdata_q;
    assign iFineGain = iFine_q[5:0];
    assign qFineGain = qFine_q[5:0];
    assign iCoarseGain = iCoarse_q[5:0];
    assign qCoarseGain = qCoarse_q[5:0];
    assign iCmResistor = iCm_q[5:0];
    assign qCmResistor = qCm_q[5:0];
    assign iCmResistorEn = iCm_q[7];
    assign qCmResistorEn = qCm_q[7];
    assign referenceTrim = ref_q[5:0];

    sequence s_tick_gap;
        calTick ##1 (!calTick)[*8];
    endsequence

    a_tick_spacing: assert property (@(posedge mclk) disable iff (!resetn)
        calTick && $stable(calCtrl_q) |-> s_tick_gap or ##1 !calCtrl_q[CLKEN_BIT])
        else $error("Calibration ticks closer than minimum divide");
    a_clock_off: assert property (@(posedge mclk) disable iff (!resetn)
        !calCtrl_q[CLKEN_BIT] |-> !calTick) else $error("Tick while clock disabled");
    a_busy_not_done: assert property (@(posedge mclk) disable iff (!resetn)
        busyI |-> !doneI) else $error("I done while running");
    a_start_runs: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(startQ) && !doneQ |=> busyQ) else $error("Q did not start");
    a_fine_reset: assert property (@(posedge mclk)
        !resetn |=> iFineGain == 6'h00 || $past(regWrite)) else $error("Fine gain not zero");
    a_cm_off_reset: assert property (@(posedge mclk)
        !resetn |=> !iCmResistorEn && !qCmResistorEn) else $error("CM resistor on");
    a_read_coef: assert property (@(posedge mclk) disable iff (!resetn)
        rdStrobeOn && !regWrite && calCtrl_q[PICKI_BIT] |=> coefData_q[5:0] == $past(rdI))
        else $error("Coefficient not presented");
    a_write_coef: assert property (@(posedge mclk) disable iff (!resetn)
        weI && !busyI |=> rdI == $past(regWdata[5:0]) || $past(coefIdx) != coefIdx)
        else $error("Coefficient not stored");
endmodule

// [sim/dsc_selfcal_top_tb.sv]
// Self-checking bench for the calibration, gain and trim register block
// Assumes the registered read port of the top module and CAL_LEN shortened to 4
`timescale 1ns/1ns
module dsc_selfcal_top_tb;
    import dsc_pkg::*;
    localparam int CAL_SIM = 4;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic [5:0] iFineGain, qFineGain, iCoarseGain, qCoarseGain;
    logic [5:0] iCmResistor, qCmResistor, referenceTrim;
    logic iCmResistorEn, qCmResistorEn, calClock;
    int errors = 0;
    int samplesChecked = 0;
    logic [7:0] expQ[$];
    logic [7:0] maskQ[$];
    logic [7:0] monMask;
    logic p1 = 1'b0;
    logic p2 = 1'b0;
    logic [5:0] coef[2][32];
    logic [4:0] trimAddr[7] = '{ADDR_I_FINE, ADDR_I_COARSE, ADDR_I_CMRES, ADDR_Q_FINE,
        ADDR_Q_COARSE, ADDR_Q_CMRES, ADDR_REF_TRIM};

    always #25 mclk = ~mclk;

    dsc_selfcal_top #(.CAL_LEN(CAL_SIM)) uut (.mclk(mclk), .resetn(resetn),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .iFineGain(iFineGain), .qFineGain(qFineGain),
        .iCoarseGain(iCoarseGain), .qCoarseGain(qCoarseGain), .iCmResistor(iCmResistor),
        .qCmResistor(qCmResistor), .iCmResistorEn(iCmResistorEn),
        .qCmResistorEn(qCmResistorEn), .referenceTrim(referenceTrim), .calClock(calClock));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge mclk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge mclk);
        regWrite = 1'b0;
    endtask

    // Read request; expected value noted for the monitor
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge mclk);
        regRead = 1'b1;
        regAddr = a;
        expQ.push_back(e & m);
        maskQ.push_back(m);
        @(negedge mclk);
        regRead = 1'b0;
        repeat (2) @(negedge mclk);
    endtask

    // Calibration clock period in mclk cycles, second rise to third rise
    task automatic measure(input int unsigned per);
        int n;
        logic prev;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                prev = calClock;
                @(negedge mclk);
                n++;
            end while (!(prev === 1'b0 && calClock === 1'b1) && n < 5000);
        end
        check(n[15:0], per[15:0]);
    endtask

    function automatic logic [6:0] portOf(input logic [4:0] a);
        case (a)
            ADDR_I_FINE: portOf = {1'b0, iFineGain};
            ADDR_I_COARSE: portOf = {1'b0, iCoarseGain};
            ADDR_I_CMRES: portOf = {iCmResistorEn, iCmResistor};
            ADDR_Q_FINE: portOf = {1'b0, qFineGain};
            ADDR_Q_COARSE: portOf = {1'b0, qCoarseGain};
            ADDR_Q_CMRES: portOf = {qCmResistorEn, qCmResistor};
            default: portOf = {1'b0, referenceTrim};
        endcase
    endfunction

    // Monitor: read data two edges after the request
    always @(posedge mclk) begin
        p1 <= regRead;
        p2 <= p1;
    end
    always @(negedge mclk) begin
        if (p2 && expQ.size() > 0) begin
            monMask = maskQ.pop_front();
            check({8'h00, regRdata & monMask}, {8'h00, expQ.pop_front()});
        end
    end

    initial begin
        repeat (80000) @(posedge mclk);
        errors++;
        stop_test();
    end

    initial begin
        logic [7:0] v;
        int hi;
        int unsigned seed;
        seed = $urandom(32'hb399);
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        check({4'h0, iFineGain, qFineGain}, 16'h0000);
        check({4'h0, iCoarseGain, qCoarseGain}, 16'h0000);
        check({2'h0, iCmResistorEn, qCmResistorEn, iCmResistor, qCmResistor}, 16'h0);
        check({9'h000, referenceTrim, calClock}, 16'h0000);
        rd(ADDR_CAL_STAT, 8'h03, 8'hc3);
        // Trims: both two's complement extremes, then random
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 7; j++) begin
                v = (k == 0) ? 8'h1f : (k == 1) ? 8'ha0 : 8'($urandom);
                wr(trimAddr[j], v);
                check({9'h0, portOf(trimAddr[j])}, {9'h0, (j == 2 || j == 5) & v[7], v[5:0]});
                rd(trimAddr[j], v, 8'hff);
            end
        end
        // Unmapped places read zero
        wr(5'h1f, 8'hff);
        rd(5'h1f, 8'h00, 8'hff);
        rd(5'h00, 8'h00, 8'hff);
        // Every divider select
        for (int d = 0; d < 8; d++) begin
            wr(ADDR_CAL_CTRL, 8'h08 | 8'(d));
            measure(32 << ((d > 6) ? 6 : d));
        end
        rd(ADDR_CAL_CTRL, 8'h0f, 8'hff);
        wr(ADDR_CAL_CTRL, 8'h00);
        repeat (2) @(negedge mclk);
        hi = 0;
        repeat (200) begin
            @(negedge mclk);
            hi = hi + ((calClock === 1'b0) ? 0 : 1);
        end
        check(hi[15:0], 16'h0000);
        // Calibration of I, Q, then both
        // Select 0 gives a 625 kHz calibration clock from 20 MHz
        for (int c = 1; c < 4; c++) begin
            wr(ADDR_MEM_CTRL, 8'h00);
            wr(ADDR_CAL_CTRL, 8'h08 | 8'(c << 4));
            wr(ADDR_MEM_CTRL, 8'h10);
            rd(ADDR_CAL_STAT, 8'h00, 8'hc0);
            repeat (40) @(negedge mclk);
            rd(ADDR_CAL_STAT, 8'h00, 8'hc0);
            repeat (200) @(negedge mclk);
            rd(ADDR_CAL_STAT, {c[1], c[0], 4'h0, ~c[1], ~c[0]}, 8'hc3);
            wr(ADDR_MEM_CTRL, 8'h00);
            rd(ADDR_CAL_STAT, 8'h00, 8'hc0);
        end
        wr(ADDR_CAL_CTRL, 8'h00);
        // Coefficient load, one channel at a time
        for (int ch = 0; ch < 2; ch++) begin
            wr(ADDR_CAL_CTRL, (ch == 1) ? 8'h20 : 8'h10);
            wr(ADDR_MEM_CTRL, 8'h08);
            for (int a = 0; a < 32; a++) begin
                coef[ch][a] = 6'($urandom);
                wr(ADDR_COEF_ADDR, 8'(a + 1));
                wr(ADDR_COEF_DATA, {2'b00, coef[ch][a]});
            end
            wr(ADDR_MEM_CTRL, 8'h00);
        end
        // Coefficient readback per channel
        for (int ch = 0; ch < 2; ch++) begin
            wr(ADDR_CAL_CTRL, (ch == 1) ? 8'h20 : 8'h10);
            for (int a = 0; a < 32; a++) begin
                wr(ADDR_COEF_ADDR, 8'(a + 1));
                wr(ADDR_MEM_CTRL, 8'h04);
                rd(ADDR_COEF_DATA, {2'b00, coef[ch][a]}, 8'h3f);
                wr(ADDR_MEM_CTRL, 8'h00);
            end
        end
        repeat (4) @(negedge mclk);
        stop_test();
    end
endmodule
